// File: rtl/cgm_pkg.sv
// constants, field layout and mode codes for the clock mode control block
package cgm_pkg;
   // register byte addresses
   localparam logic [7:0] CGM_CTRL1_ADDR = 8'h00;
   localparam logic [7:0] CGM_STATUS_ADDR = 8'h04;
   // control register field positions
   localparam int CGM_HGO_BIT = 7;
   localparam int CGM_RANGE_BIT = 6;
   localparam int CGM_EXT_REF_SELECT_BIT = 5;
   localparam int CGM_MODE_HI = 4;
   localparam int CGM_MODE_LO = 3;
   localparam int CGM_OSCOFF_BIT = 2;
   localparam int CGM_LOCD_BIT = 1;
   // status register field positions
   localparam int CGM_ST_MODE_HI = 7;
   localparam int CGM_ST_MODE_LO = 6;
   localparam int CGM_ST_REFOK_BIT = 5;
   localparam int CGM_ST_PEND_BIT = 4;
   localparam int CGM_ST_FIRST_BIT = 3;
   localparam int CGM_ST_PINRES_BIT = 2;
   // clock mode codes
   localparam logic [1:0] CGM_MODE_SCM = 2'h0;
   localparam logic [1:0] CGM_MODE_FEI = 2'h1;
   localparam logic [1:0] CGM_MODE_FBE = 2'h2;
   localparam logic [1:0] CGM_MODE_FEE = 2'h3;
   // reset values and loop prescale factors
   localparam logic [2:0] CGM_ONCE_RST = 3'h0;
   localparam logic [1:0] CGM_MISC_RST = 2'h0;
   localparam logic [6:0] CGM_PRESCALE_LOW = 7'h40;
   localparam logic [6:0] CGM_PRESCALE_HIGH = 7'h01;
   localparam logic [31:0] CGM_ZERO_WORD = 32'h0;
   // mode switch sequencer states
   typedef enum logic {CGM_SW_IDLE, CGM_SW_WAIT} cgm_sw_e;
endpackage

// File: rtl/cgm_sync.sv
// two flop synchroniser for levels entering the bus clock domain
module cgm_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // level in and synchronised level out
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] stage1;

   // stage1 is read only by the second flop
   always_ff @(posedge mclk) begin
      if (rst) begin
         stage1 <= '0;
         dout <= '0;
      end else begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule // cgm_sync

// File: rtl/cgm_once_reg.sv
// write once register: keeps only the first load after reset
module cgm_once_reg #(
   parameter int W = 3,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // load strobe and data
   input wire logic load,
   input wire logic [W-1:0] d,
   // stored value and lock flag
   output logic [W-1:0] q,
   output logic done
);
   // later loads are dropped until the next reset
   always_ff @(posedge mclk) begin
      if (rst) begin
         q <= RST_VAL;
         done <= 1'b0;
      end else if (load && !done) begin
         q <= d;
         done <= 1'b1;
      end
   end
endmodule // cgm_once_reg

// File: rtl/cgm_mode_ctrl.sv
// clock generator mode select and oscillator configuration, apb slave
module cgm_mode_ctrl
   import cgm_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // clock generator environment
   input wire logic extRefClockOk,
   input wire logic offModeReq,
   // oscillator configuration
   output logic oscHighGainSel,
   output logic extRefSelect,
   output logic [6:0] loopPrescale,
   output logic [1:0] activeMode,
   output logic clockStatic,
   // oscillator pin use
   output logic extClockInEn,
   output logic oscInEn,
   output logic oscOutEn
);
   ////////////////////////////////////////////////////////////////////////
   // bus decode
   logic access;
   logic wrCtrl;
   logic hitCtrl;
   logic hitStatus;
   logic [2:0] onceQ;
   logic firstDone;
   logic [1:0] modeSelect;
   logic [1:0] miscBits;
   logic pinReserved;
   logic refOkSync;
   logic [1:0] modeStatus;
   logic [1:0] wrMode;
   logic modeWriteOk;
   cgm_sw_e swState;
   cgm_sw_e next_swState;
   logic switchDone;

   assign hitCtrl = (paddr == CGM_CTRL1_ADDR);
   assign hitStatus = (paddr == CGM_STATUS_ADDR);
   assign access = psel && penable && pready;
   assign wrCtrl = access && pwrite && hitCtrl;
   assign wrMode = pwdata[CGM_MODE_HI:CGM_MODE_LO];

   // one wait state: pready rises on the second access cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
      end
   end

   // read data and error are set up with pready, unmapped gives an error
   always_ff @(posedge mclk) begin
      if (rst) begin
         prdata <= CGM_ZERO_WORD;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         prdata <= CGM_ZERO_WORD;
         pslverr <= !(hitCtrl || hitStatus);
         if (!pwrite && hitCtrl) begin
            prdata[CGM_HGO_BIT] <= onceQ[2];
            prdata[CGM_RANGE_BIT] <= onceQ[1];
            prdata[CGM_EXT_REF_SELECT_BIT] <= onceQ[0];
            prdata[CGM_MODE_HI:CGM_MODE_LO] <= modeSelect;
            prdata[CGM_OSCOFF_BIT:CGM_LOCD_BIT] <= miscBits;
         end else if (!pwrite && hitStatus) begin
            prdata[CGM_ST_MODE_HI:CGM_ST_MODE_LO] <= modeStatus;
            prdata[CGM_ST_REFOK_BIT] <= refOkSync;
            prdata[CGM_ST_PEND_BIT] <= (swState == CGM_SW_WAIT);
            prdata[CGM_ST_FIRST_BIT] <= firstDone;
            prdata[CGM_ST_PINRES_BIT] <= pinReserved;
         end
      end else begin
         pslverr <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write once fields: gain, range, reference source
   // the lock flag of this register doubles as the first write marker
   cgm_once_reg #(
      .W(3),
      .RST_VAL(CGM_ONCE_RST)
   ) u_once (
      .mclk(mclk),
      .rst(rst),
      .load(wrCtrl),
      .d({pwdata[CGM_HGO_BIT], pwdata[CGM_RANGE_BIT], pwdata[CGM_EXT_REF_SELECT_BIT]}),
      .q(onceQ),
      .done(firstDone)
   );

   // plain read/write bits kept for software, not used by this block
   always_ff @(posedge mclk) begin
      if (rst) begin
         miscBits <= CGM_MISC_RST;
      end else if (wrCtrl) begin
         miscBits <= pwdata[CGM_OSCOFF_BIT:CGM_LOCD_BIT];
      end
   end

   // first write decides whether the external pin is reserved
   always_ff @(posedge mclk) begin
      if (rst) begin
         pinReserved <= 1'b0;
      end else if (wrCtrl && !firstDone) begin
         pinReserved <= wrMode[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mode select field and switch sequencer
   // a 1X request without a reserved pin would starve the clock tree
   assign modeWriteOk = wrCtrl && (swState == CGM_SW_IDLE)
      && !(firstDone && !pinReserved && wrMode[1]);

   always_ff @(posedge mclk) begin
      if (rst) begin
         modeSelect <= CGM_MODE_SCM;
      end else if (modeWriteOk) begin
         modeSelect <= wrMode;
      end
   end

   // bypass only after the reference is seen valid; off mode freezes it
   assign switchDone = !offModeReq
      && (modeSelect != CGM_MODE_FBE || refOkSync);

   always_comb begin
      next_swState = swState;
      unique case (swState)
         CGM_SW_IDLE: begin
            if (modeWriteOk) begin
               next_swState = CGM_SW_WAIT;
            end
         end
         CGM_SW_WAIT: begin
            if (switchDone) begin
               next_swState = CGM_SW_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         swState <= CGM_SW_IDLE;
      end else begin
         swState <= next_swState;
      end
   end

   // active mode follows the select once the switch completes
   always_ff @(posedge mclk) begin
      if (rst) begin
         activeMode <= CGM_MODE_SCM;
      end else if (swState == CGM_SW_WAIT && switchDone) begin
         activeMode <= modeSelect;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // crossings: reference status in, mode status back to software
   cgm_sync #(.W(1)) u_refok (
      .mclk(mclk),
      .rst(rst),
      .din(extRefClockOk),
      .dout(refOkSync)
   );

   cgm_sync #(.W(2)) u_modest (
      .mclk(mclk),
      .rst(rst),
      .din(activeMode),
      .dout(modeStatus)
   );

   ////////////////////////////////////////////////////////////////////////
   // oscillator configuration outputs
   always_ff @(posedge mclk) begin
      if (rst) begin
         oscHighGainSel <= 1'b0;
         extRefSelect <= 1'b0;
         loopPrescale <= CGM_PRESCALE_LOW;
         clockStatic <= 1'b0;
      end else begin
         oscHighGainSel <= onceQ[2];
         extRefSelect <= onceQ[0];
         // internal modes keep the fixed low range prescale
         if (activeMode[1] && onceQ[1]) begin
            loopPrescale <= CGM_PRESCALE_HIGH;
         end else begin
            loopPrescale <= CGM_PRESCALE_LOW;
         end
         clockStatic <= offModeReq;
      end
   end

   // pin functions, fixed by the first control write
   always_ff @(posedge mclk) begin
      if (rst) begin
         extClockInEn <= 1'b0;
         oscInEn <= 1'b0;
         oscOutEn <= 1'b0;
      end else begin
         extClockInEn <= pinReserved && !onceQ[0];
         oscInEn <= pinReserved && onceQ[0];
         oscOutEn <= pinReserved;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_gain_once: assert property (
      firstDone && wrCtrl |=> $stable(onceQ[2]))
      else $error("gain select changed after first write");
   a_range_once: assert property (
      firstDone && wrCtrl |=> $stable(onceQ[1]))
      else $error("range select changed after first write");
   a_ext_ref_select_once: assert property (
      firstDone && wrCtrl |=> $stable(onceQ[0]))
      else $error("reference select changed after first write");
   a_gain_out: assert property (
      ##1 oscHighGainSel == $past(onceQ[2]))
      else $error("gain output does not follow gain select");
   a_prescale_int: assert property (
      !activeMode[1] |=> loopPrescale == CGM_PRESCALE_LOW)
      else $error("range applied in an internal mode");
   a_byp_wait: assert property (
      swState == CGM_SW_WAIT && modeSelect == CGM_MODE_FBE && !refOkSync
      |=> $stable(activeMode))
      else $error("bypass entered before reference valid");
   a_pend_ignore: assert property (
      swState == CGM_SW_WAIT |=> $stable(modeSelect))
      else $error("mode write taken while switch pending");
   a_ext_block: assert property (
      firstDone && !pinReserved |-> !modeSelect[1])
      else $error("external mode selected without reserved pin");
   a_osc_out: assert property (
      pinReserved |=> oscOutEn)
      else $error("oscillator output pin not enabled");
   a_status_lag: assert property (
      $changed(activeMode) |-> ##2 modeStatus == $past(activeMode, 2))
      else $error("mode status does not follow active mode");
   a_off_keep: assert property (
      offModeReq && !modeWriteOk |=> $stable(modeSelect))
      else $error("mode select changed on off mode");
   // pin use and prescale follow the stored first write
   a_prescale_ext: assert property (
      activeMode[1] && onceQ[1] |=> loopPrescale == CGM_PRESCALE_HIGH)
      else $error("high range prescale not applied");
   a_range_low: assert property (
      !onceQ[1] |=> loopPrescale == CGM_PRESCALE_LOW)
      else $error("low range prescale not applied");
   a_ext_ref_select_out: assert property (
      ##1 extRefSelect == $past(onceQ[0]))
      else $error("reference select output does not follow select");
   a_pin_ext: assert property (
      pinReserved |=> extClockInEn == !$past(onceQ[0])
      && oscInEn == $past(onceQ[0]))
      else $error("external pin function does not match source");
   a_pin_free: assert property (
      !pinReserved |=> !extClockInEn && !oscInEn && !oscOutEn)
      else $error("oscillator pin used without reservation");
   // first write marker and mode field handling
   a_first_mark: assert property (
      wrCtrl |=> firstDone)
      else $error("first write not recorded");
   a_mode_take: assert property (
      modeWriteOk |=> modeSelect == $past(wrMode))
      else $error("accepted mode write not stored");
   a_off_freeze: assert property (
      offModeReq && swState == CGM_SW_WAIT
      |=> swState == CGM_SW_WAIT && $stable(activeMode))
      else $error("mode switch completed during off mode");
   // bus handshake: one ready pulse per access
   a_ready_pulse: assert property (
      pready |=> !pready)
      else $error("ready held for more than one cycle");

   c_fee_switch: cover property (
      activeMode == CGM_MODE_SCM ##[1:20] activeMode == CGM_MODE_FEE);
   c_fbe_wait: cover property (
      swState == CGM_SW_WAIT && !refOkSync ##[1:20] activeMode == CGM_MODE_FBE);
   c_ext_refused: cover property (
      wrCtrl && firstDone && !pinReserved && wrMode[1]);
   c_off_hold: cover property (
      offModeReq && swState == CGM_SW_WAIT);
   c_int_first: cover property (
      wrCtrl && !firstDone && !wrMode[1]);
endmodule // cgm_mode_ctrl

// File: tb/cgm_ref_model.sv
// behavioural external clock source feeding the reference valid flag
module cgm_ref_model #(
   parameter int START = 4
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // pin use from the block and source run control
   input wire logic extClockInEn,
   input wire logic oscInEn,
   input wire logic refRun,
   // reference valid
   output logic extRefClockOk
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;
   ////////////////////////////////////////////////////////////////////////
   // startup count: a source only runs once its pin has been reserved
   always_ff @(posedge mclk) begin
      if (rst || !refRun || !(extClockInEn || oscInEn)) begin
         cnt <= 0;
      end else if (cnt < START) begin
         cnt <= cnt + 1;
      end
   end
   // a stopped source drops valid at once, as a real monitor would see it
   assign extRefClockOk = refRun && (cnt == START);
endmodule // cgm_ref_model

// File: tb/cgm_mode_ctrl_bench.sv
// self-checking bench for the clock mode control block
module cgm_mode_ctrl_bench;
   import cgm_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, extRefClockOk, offModeReq = 0, refRun = 1;
   logic oscHighGainSel, extRefSelect, clockStatic;
   logic extClockInEn, oscInEn, oscOutEn;
   logic [6:0] loopPrescale;
   logic [1:0] activeMode;
   int err_count = 0, compares = 0;
   ////////////////////////////////////////////////////////////////////////
   // clock, design and reference source
   always #50 mclk = ~mclk;
   cgm_mode_ctrl dut_u (.mclk(mclk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .extRefClockOk(extRefClockOk), .offModeReq(offModeReq),
      .oscHighGainSel(oscHighGainSel), .extRefSelect(extRefSelect),
      .loopPrescale(loopPrescale), .activeMode(activeMode),
      .clockStatic(clockStatic), .extClockInEn(extClockInEn),
      .oscInEn(oscInEn), .oscOutEn(oscOutEn));
   cgm_ref_model ref_u (.mclk(mclk), .rst(rst), .extClockInEn(extClockInEn),
      .oscInEn(oscInEn), .refRun(refRun), .extRefClockOk(extRefClockOk));
   ////////////////////////////////////////////////////////////////////////
   // shared helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; the request stands until pready is seen high or 20 cycles pass
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) chk(32'h1, 32'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, {24'h0, d}, q, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x,
      input logic xe);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask
   // let registered outputs settle, then sample clear of the edge
   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // reset pulse, then reset state of every output and register
   task automatic do_reset();
      @(posedge mclk);
      rst <= 1'b1;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      settle(1);
      chk({oscHighGainSel, extRefSelect, extClockInEn, oscInEn}, 0);
      chk({oscOutEn, clockStatic, activeMode}, 0);
      chk(loopPrescale, 7'h40);
      rd(CGM_CTRL1_ADDR, 32'h0, 1'b0);
      rd(CGM_STATUS_ADDR, 32'h0, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // external first write, locks, deferred bypass switch and off mode
   task automatic scen_external();
      wr(CGM_CTRL1_ADDR, 8'hf8);
      settle(4);
      chk({oscHighGainSel, extRefSelect}, 2'h3);
      chk({extClockInEn, oscInEn, oscOutEn}, 3'h3);
      chk(activeMode, CGM_MODE_FEE);
      chk(loopPrescale, 7'h01);
      wr(CGM_CTRL1_ADDR, 8'h08);
      settle(4);
      chk({oscHighGainSel, extRefSelect}, 2'h3);
      chk(activeMode, CGM_MODE_FEI);
      chk(loopPrescale, 7'h40);
      wr(CGM_CTRL1_ADDR, 8'h18);
      settle(4);
      chk(loopPrescale, 7'h01);
      rd(CGM_STATUS_ADDR, 32'hec, 1'b0);
      @(posedge mclk);
      refRun <= 1'b0;
      settle(4);
      wr(CGM_CTRL1_ADDR, 8'h10);
      settle(4);
      chk(activeMode, CGM_MODE_FEE);
      wr(CGM_CTRL1_ADDR, 8'h00);
      offModeReq <= 1'b1;
      refRun <= 1'b1;
      settle(10);
      chk({clockStatic, activeMode}, {1'b1, CGM_MODE_FEE});
      rd(CGM_CTRL1_ADDR, 32'hf0, 1'b0);
      offModeReq <= 1'b0;
      settle(6);
      chk(activeMode, CGM_MODE_FBE);
   endtask
   // internal first write leaves pins free and bars external modes
   task automatic scen_internal();
      do_reset();
      wr(CGM_CTRL1_ADDR, 8'h08);
      settle(4);
      chk({extClockInEn, oscInEn, oscOutEn}, 3'h0);
      chk(activeMode, CGM_MODE_FEI);
      wr(CGM_CTRL1_ADDR, 8'h18);
      settle(6);
      chk(activeMode, CGM_MODE_FEI);
      wr(CGM_CTRL1_ADDR, 8'h00);
      settle(4);
      chk(activeMode, CGM_MODE_SCM);
      rd(8'h08, 32'h0, 1'b1);
   endtask
   // external clock input first, bypass waits for the reference
   task automatic scen_bypass();
      do_reset();
      wr(CGM_CTRL1_ADDR, 8'h10);
      settle(3);
      chk({extClockInEn, oscInEn, oscOutEn}, 3'h5);
      chk({oscHighGainSel, extRefSelect}, 2'h0);
      chk(activeMode, CGM_MODE_SCM);
      settle(8);
      chk(activeMode, CGM_MODE_FBE);
      chk(loopPrescale, 7'h40);
      wr(CGM_CTRL1_ADDR, 8'hf0);
      settle(4);
      chk({oscHighGainSel, extRefSelect}, 2'h0);
      chk(loopPrescale, 7'h40);
      rd(CGM_CTRL1_ADDR, 32'h10, 1'b0);
      rd(CGM_STATUS_ADDR, 32'hac, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic complete_run();
      $display("errors %0d of %0d compares", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      do_reset();
      scen_external();
      scen_internal();
      scen_bypass();
      complete_run();
   end
   // the whole run needs well under a thousand cycles
   initial begin
      #200000;
      err_count++;
      complete_run();
   end
endmodule // cgm_mode_ctrl_bench
